// ===== gpe_pkg.sv
// Shared constants, register map and carrier types of the GPIO port with edge event lines
package gpe_pkg;

  localparam int NUM_PINS       = 16;
  localparam int NUM_LINES      = 29;
  localparam int NUM_PIN_LINES  = 16;
  localparam int NUM_INT_LINES  = 13;
  localparam int NUM_SRC_PINS   = 84;
  localparam int NUM_OTHER_PINS = 68;
  localparam int NUM_AF         = 8;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_OTYPE  = 8'h04;
  localparam logic [7:0] ADDR_SPEED  = 8'h08;
  localparam logic [7:0] ADDR_PULL   = 8'h0C;
  localparam logic [7:0] ADDR_ODATA  = 8'h10;
  localparam logic [7:0] ADDR_IDATA  = 8'h14;
  localparam logic [7:0] ADDR_AF_LO  = 8'h18;
  localparam logic [7:0] ADDR_AF_HI  = 8'h1C;
  localparam logic [7:0] ADDR_LOCK   = 8'h20;
  localparam logic [7:0] ADDR_RISE   = 8'h40;
  localparam logic [7:0] ADDR_FALL   = 8'h44;
  localparam logic [7:0] ADDR_IEN    = 8'h48;
  localparam logic [7:0] ADDR_EEN    = 8'h4C;
  localparam logic [7:0] ADDR_PEND   = 8'h50;
  localparam logic [7:0] ADDR_PCLR   = 8'h54;
  localparam logic [7:0] ADDR_SRC_LO = 8'h58;
  localparam logic [7:0] ADDR_SRC_HI = 8'h5C;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Field layout and encodings
  localparam int         MODE_W       = 2;
  localparam int         SPEED_W      = 2;
  localparam int         PULL_W       = 2;
  localparam int         AF_W         = 4;
  localparam int         SRC_W        = 4;
  localparam int         LOCK_KEY_BIT = 16;
  localparam logic [1:0] MODE_INPUT   = 2'h0;
  localparam logic [1:0] MODE_OUTPUT  = 2'h1;
  localparam logic [1:0] MODE_ALTFN   = 2'h2;
  localparam logic [1:0] MODE_ANALOG  = 2'h3;
  localparam logic [1:0] PULL_NONE    = 2'h0;
  localparam logic [1:0] PULL_UP      = 2'h1;
  localparam logic [1:0] PULL_DOWN    = 2'h2;
  localparam logic [1:0] SPEED_400K   = 2'h0;
  localparam logic [1:0] SPEED_2M     = 2'h1;
  localparam logic [1:0] SPEED_10M    = 2'h2;
  localparam logic [1:0] SPEED_40M    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] MODE_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [28:0] EVT_RST   = 29'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gpe_bus_req_type;

  typedef struct packed {
    logic [1:0] mode;
    logic       otype;
    logic [1:0] speed;
    logic [1:0] pull;
    logic [2:0] af;
  } gpe_pin_cfg_type;

endpackage

// ===== gpe_edge_cap.sv
// Clockless edge capture for one event line, handed over to the bus clock by toggles
`timescale 1ns/100ps
`default_nettype none
module gpe_edge_cap (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic src,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      hit,
  output logic      wake
);
  logic       rise_tog_q;
  logic       rise_tog_d;
  logic       fall_tog_q;
  logic       fall_tog_d;
  logic [1:0] rise_sync_q;
  logic [1:0] fall_sync_q;
  logic       rise_seen_q;
  logic       fall_seen_q;

  always_comb begin
    rise_tog_d = ~rise_tog_q;
    fall_tog_d = ~fall_tog_q;
  end

  // The source itself clocks the toggles, so pulses shorter than a bus clock survive
  always_ff @(posedge src or negedge rst_n) begin
    if (!rst_n) rise_tog_q <= 1'b0;
    else rise_tog_q <= rise_tog_d;
  end

  always_ff @(negedge src or negedge rst_n) begin
    if (!rst_n) fall_tog_q <= 1'b0;
    else fall_tog_q <= fall_tog_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sync_q <= 2'h0;
      fall_sync_q <= 2'h0;
      rise_seen_q <= 1'b0;
      fall_seen_q <= 1'b0;
    end else begin
      rise_sync_q <= {rise_sync_q[0], rise_tog_q};
      fall_sync_q <= {fall_sync_q[0], fall_tog_q};
      rise_seen_q <= rise_sync_q[1];
      fall_seen_q <= fall_sync_q[1];
    end
  end

  assign hit = (rise_en & (rise_sync_q[1] ^ rise_seen_q))
             | (fall_en & (fall_sync_q[1] ^ fall_seen_q));
  // Needs no clock: raised straight from the toggles while the bus clock is stopped
  assign wake = (rise_en & (rise_tog_q ^ rise_seen_q))
              | (fall_en & (fall_tog_q ^ fall_seen_q));
endmodule
`default_nettype wire

// ===== gpe_pin_cell.sv
// Output driver, pull and input stage of one port pin
`timescale 1ns/100ps
`default_nettype none
module gpe_pin_cell (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire gpe_pkg::gpe_pin_cfg_type cfg,
  input  wire logic                     odata,
  input  wire logic [7:0]               af_out,
  input  wire logic                     pin_in,
  output logic                          pin_out,
  output logic                          pin_oe_n,
  output logic                          pull_up,
  output logic                          pull_dn,
  output logic [1:0]                    speed,
  output logic                          in_val
);
  logic       drive_val;
  logic       drive_on;
  logic [5:0] cell_d;
  logic [5:0] cell_q;

  always_comb begin
    drive_val = (cfg.mode == gpe_pkg::MODE_ALTFN) ? af_out[cfg.af] : odata;
    drive_on  = (cfg.mode == gpe_pkg::MODE_OUTPUT) || (cfg.mode == gpe_pkg::MODE_ALTFN);
    // Open drain only pulls low; a one releases the pin
    cell_d[0] = drive_val & ~cfg.otype;
    cell_d[1] = ~(drive_on & (~cfg.otype | ~drive_val));
    cell_d[2] = (cfg.pull == gpe_pkg::PULL_UP) && (cfg.mode != gpe_pkg::MODE_ANALOG);
    cell_d[3] = (cfg.pull == gpe_pkg::PULL_DOWN) && (cfg.mode != gpe_pkg::MODE_ANALOG);
    // Analog pins read as zero so the digital input does not toggle
    cell_d[4] = pin_in & (cfg.mode != gpe_pkg::MODE_ANALOG);
    cell_d[5] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_q <= 6'h02;
      speed  <= gpe_pkg::SPEED_400K;
    end else begin
      cell_q <= cell_d;
      speed  <= cfg.speed;
    end
  end

  assign pin_out  = cell_q[0];
  assign pin_oe_n = cell_q[1];
  assign pull_up  = cell_q[2];
  assign pull_dn  = cell_q[3];
  assign in_val   = cell_q[4];

  af_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.mode == gpe_pkg::MODE_ALTFN && !cfg.otype) |=> (pin_out == $past(af_out[cfg.af])))
    else $error("Alternate function value not routed to pin");
endmodule
`default_nettype wire

// ===== gpe_port_top.sv
// GPIO port with pin configuration, configuration lock and 29 edge event lines
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gpe_port_top (
  input  wire logic                     CLK,
  input  wire logic                     RESET_N,
  input  wire gpe_pkg::gpe_bus_req_type BUS_REQ,
  output logic [31:0]                   BUS_RDATA,
  input  wire logic [15:0]              PIN_IN,
  output logic [15:0]                   PIN_OUT,
  output logic [15:0]                   PIN_OE_N,
  output logic [15:0]                   PIN_PULL_UP,
  output logic [15:0]                   PIN_PULL_DOWN,
  output logic [31:0]                   PIN_SPEED,
  input  wire logic [15:0][7:0]         AF_OUT,
  output logic [15:0]                   AF_IN,
  input  wire logic [67:0]              OTHER_PINS_IN,
  input  wire logic [12:0]              INT_EVENT_IN,
  output logic                          IRQ,
  output logic [28:0]                   EVENT_OUT,
  output logic                          WAKE_OUT
);
  typedef enum {LK_IDLE, LK_GOT_ONE, LK_GOT_ZERO} gpe_lock_state_type;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Keeps the bits of locked pins; w is the field width per pin
  function automatic logic [31:0] lock_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [15:0] lk,
                                             input int          w);
    logic [31:0] res;
    res = new_v;
    for (int b = 0; b < 32; b++) begin
      if ((b / w) < 16) begin
        if (lk[4'(b / w)]) res[b] = old_v[b];
      end
    end
    return res;
  endfunction

  // Picks pin source for a pin line: port number times sixteen plus line number
  function automatic logic src_pick(input logic [3:0] sel,
                                    input int          line,
                                    input logic [83:0] all);
    int idx;
    idx = 32'(sel) * 16 + line;
    if (idx < gpe_pkg::NUM_SRC_PINS) return all[idx];
    return 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration and lock state

  logic [31:0]        mode_q, mode_d;
  logic [15:0]        otype_q, otype_d;
  logic [31:0]        speed_q, speed_d;
  logic [31:0]        pull_q, pull_d;
  logic [15:0]        odata_q, odata_d;
  logic [31:0]        af_lo_q, af_lo_d;
  logic [31:0]        af_hi_q, af_hi_d;
  logic [15:0]        lock_mask_q, lock_mask_d;
  logic [15:0]        lock_q, lock_d;
  logic               lock_on_q, lock_on_d;
  gpe_lock_state_type lk_state_q, lk_state_d;
  logic               wr_hit;
  logic               lock_key;

  always_comb begin
    mode_d      = mode_q;
    otype_d     = otype_q;
    speed_d     = speed_q;
    pull_d      = pull_q;
    odata_d     = odata_q;
    af_lo_d     = af_lo_q;
    af_hi_d     = af_hi_q;
    lock_mask_d = lock_mask_q;
    lock_d      = lock_q;
    lock_on_d   = lock_on_q;
    lk_state_d  = lk_state_q;
    wr_hit      = BUS_REQ.wr;
    lock_key    = BUS_REQ.wdata[gpe_pkg::LOCK_KEY_BIT];
    if (wr_hit) begin
      unique case (BUS_REQ.addr)
        gpe_pkg::ADDR_MODE:
          mode_d = lock_merge(mode_q, BUS_REQ.wdata, lock_q, gpe_pkg::MODE_W);
        gpe_pkg::ADDR_OTYPE:
          otype_d = 16'(lock_merge({16'h0000, otype_q}, BUS_REQ.wdata, lock_q, 1));
        gpe_pkg::ADDR_SPEED:
          speed_d = lock_merge(speed_q, BUS_REQ.wdata, lock_q, gpe_pkg::SPEED_W);
        gpe_pkg::ADDR_PULL:
          pull_d = lock_merge(pull_q, BUS_REQ.wdata, lock_q, gpe_pkg::PULL_W);
        gpe_pkg::ADDR_ODATA:
          odata_d = BUS_REQ.wdata[15:0];
        gpe_pkg::ADDR_AF_LO:
          af_lo_d = lock_merge(af_lo_q, BUS_REQ.wdata, {8'h00, lock_q[7:0]}, gpe_pkg::AF_W);
        gpe_pkg::ADDR_AF_HI:
          af_hi_d = lock_merge(af_hi_q, BUS_REQ.wdata, {8'h00, lock_q[15:8]}, gpe_pkg::AF_W);
        gpe_pkg::ADDR_LOCK: begin
          // Key one, key zero, key one with the same mask; anything else restarts
          if (!lock_on_q) begin
            unique case (lk_state_q)
              LK_IDLE: begin
                lk_state_d  = lock_key ? LK_GOT_ONE : LK_IDLE;
                lock_mask_d = BUS_REQ.wdata[15:0];
              end
              LK_GOT_ONE:
                lk_state_d = (!lock_key && BUS_REQ.wdata[15:0] == lock_mask_q) ?
                             LK_GOT_ZERO : LK_IDLE;
              LK_GOT_ZERO: begin
                lk_state_d = LK_IDLE;
                if (lock_key && BUS_REQ.wdata[15:0] == lock_mask_q) begin
                  lock_on_d = 1'b1;
                  lock_d    = lock_mask_q;
                end
              end
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // Lock holds until reset; there is no unlock path by design
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q      <= gpe_pkg::MODE_RST;
      otype_q     <= 16'h0000;
      speed_q     <= gpe_pkg::CFG_RST;
      pull_q      <= gpe_pkg::CFG_RST;
      odata_q     <= 16'h0000;
      af_lo_q     <= gpe_pkg::CFG_RST;
      af_hi_q     <= gpe_pkg::CFG_RST;
      lock_mask_q <= 16'h0000;
      lock_q      <= 16'h0000;
      lock_on_q   <= 1'b0;
      lk_state_q  <= LK_IDLE;
    end else begin
      mode_q      <= mode_d;
      otype_q     <= otype_d;
      speed_q     <= speed_d;
      pull_q      <= pull_d;
      odata_q     <= odata_d;
      af_lo_q     <= af_lo_d;
      af_hi_q     <= af_hi_d;
      lock_mask_q <= lock_mask_d;
      lock_q      <= lock_d;
      lock_on_q   <= lock_on_d;
      lk_state_q  <= lk_state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin cells

  logic [15:0]                  in_val;
  gpe_pkg::gpe_pin_cfg_type     pin_cfg [16];
  logic [63:0]                  af_all;

  assign af_all = {af_hi_q, af_lo_q};

  for (genvar p = 0; p < gpe_pkg::NUM_PINS; p++) begin : g_pin
    always_comb begin
      pin_cfg[p].mode  = mode_q[2*p +: 2];
      pin_cfg[p].otype = otype_q[p];
      pin_cfg[p].speed = speed_q[2*p +: 2];
      pin_cfg[p].pull  = pull_q[2*p +: 2];
      pin_cfg[p].af    = af_all[4*p +: 3];
    end
    gpe_pin_cell u_cell (
      .clk      (CLK),
      .rst_n    (RESET_N),
      .cfg      (pin_cfg[p]),
      .odata    (odata_q[p]),
      .af_out   (AF_OUT[p]),
      .pin_in   (PIN_IN[p]),
      .pin_out  (PIN_OUT[p]),
      .pin_oe_n (PIN_OE_N[p]),
      .pull_up  (PIN_PULL_UP[p]),
      .pull_dn  (PIN_PULL_DOWN[p]),
      .speed    (PIN_SPEED[2*p +: 2]),
      .in_val   (in_val[p])
    );
  end

  assign AF_IN = in_val;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Edge event lines

  logic [28:0] rise_q, rise_d;
  logic [28:0] fall_q, fall_d;
  logic [28:0] ien_q, ien_d;
  logic [28:0] een_q, een_d;
  logic [28:0] pend_q, pend_d;
  logic [28:0] event_q, event_d;
  logic [31:0] src_lo_q, src_lo_d;
  logic [31:0] src_hi_q, src_hi_d;
  logic [28:0] line_src;
  logic [28:0] hit_vec;
  logic [28:0] wake_vec;
  logic [28:0] clr_vec;
  logic [63:0] src_all;
  logic [83:0] pin_pool;

  assign src_all  = {src_hi_q, src_lo_q};
  // Raw pins, not the registered copy: the capture must not wait for a clock
  assign pin_pool = {OTHER_PINS_IN, PIN_IN};

  for (genvar l = 0; l < gpe_pkg::NUM_LINES; l++) begin : g_line
    if (l < gpe_pkg::NUM_PIN_LINES) begin : g_pin_src
      assign line_src[l] = src_pick(src_all[4*l +: 4], l, pin_pool);
    end else begin : g_int_src
      assign line_src[l] = INT_EVENT_IN[l - gpe_pkg::NUM_PIN_LINES];
    end
    gpe_edge_cap u_cap (
      .clk     (CLK),
      .rst_n   (RESET_N),
      .src     (line_src[l]),
      .rise_en (rise_q[l]),
      .fall_en (fall_q[l]),
      .hit     (hit_vec[l]),
      .wake    (wake_vec[l])
    );
  end

  always_comb begin
    rise_d   = rise_q;
    fall_d   = fall_q;
    ien_d    = ien_q;
    een_d    = een_q;
    src_lo_d = src_lo_q;
    src_hi_d = src_hi_q;
    clr_vec  = '0;
    if (BUS_REQ.wr) begin
      unique case (BUS_REQ.addr)
        gpe_pkg::ADDR_RISE:   rise_d   = BUS_REQ.wdata[28:0];
        gpe_pkg::ADDR_FALL:   fall_d   = BUS_REQ.wdata[28:0];
        gpe_pkg::ADDR_IEN:    ien_d    = BUS_REQ.wdata[28:0];
        gpe_pkg::ADDR_EEN:    een_d    = BUS_REQ.wdata[28:0];
        gpe_pkg::ADDR_PCLR:   clr_vec  = BUS_REQ.wdata[28:0];
        gpe_pkg::ADDR_SRC_LO: src_lo_d = BUS_REQ.wdata;
        gpe_pkg::ADDR_SRC_HI: src_hi_d = BUS_REQ.wdata;
        default: ;
      endcase
    end
    // A new hit in the clearing cycle wins
    pend_d  = (pend_q & ~clr_vec) | hit_vec;
    event_d = hit_vec & een_q;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rise_q   <= gpe_pkg::EVT_RST;
      fall_q   <= gpe_pkg::EVT_RST;
      ien_q    <= gpe_pkg::EVT_RST;
      een_q    <= gpe_pkg::EVT_RST;
      pend_q   <= gpe_pkg::EVT_RST;
      event_q  <= gpe_pkg::EVT_RST;
      src_lo_q <= gpe_pkg::CFG_RST;
      src_hi_q <= gpe_pkg::CFG_RST;
    end else begin
      rise_q   <= rise_d;
      fall_q   <= fall_d;
      ien_q    <= ien_d;
      een_q    <= een_d;
      pend_q   <= pend_d;
      event_q  <= event_d;
      src_lo_q <= src_lo_d;
      src_hi_q <= src_hi_d;
    end
  end

  assign EVENT_OUT = event_q;
  assign IRQ       = |(pend_q & ien_q);
  assign WAKE_OUT  = |(wake_vec & (ien_q | een_q));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = gpe_pkg::RDATA_RST;
    if (BUS_REQ.rd) begin
      unique case (BUS_REQ.addr)
        gpe_pkg::ADDR_MODE:   rdata_d = mode_q;
        gpe_pkg::ADDR_OTYPE:  rdata_d = {16'h0000, otype_q};
        gpe_pkg::ADDR_SPEED:  rdata_d = speed_q;
        gpe_pkg::ADDR_PULL:   rdata_d = pull_q;
        gpe_pkg::ADDR_ODATA:  rdata_d = {16'h0000, odata_q};
        gpe_pkg::ADDR_IDATA:  rdata_d = {16'h0000, in_val};
        gpe_pkg::ADDR_AF_LO:  rdata_d = af_lo_q;
        gpe_pkg::ADDR_AF_HI:  rdata_d = af_hi_q;
        gpe_pkg::ADDR_LOCK:   rdata_d = {15'h0000, lock_on_q, lock_q};
        gpe_pkg::ADDR_RISE:   rdata_d = {3'h0, rise_q};
        gpe_pkg::ADDR_FALL:   rdata_d = {3'h0, fall_q};
        gpe_pkg::ADDR_IEN:    rdata_d = {3'h0, ien_q};
        gpe_pkg::ADDR_EEN:    rdata_d = {3'h0, een_q};
        gpe_pkg::ADDR_PEND:   rdata_d = {3'h0, pend_q};
        gpe_pkg::ADDR_SRC_LO: rdata_d = src_lo_q;
        gpe_pkg::ADDR_SRC_HI: rdata_d = src_hi_q;
        default:              rdata_d = gpe_pkg::RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rdata_q <= gpe_pkg::RDATA_RST;
    else rdata_q <= rdata_d;
  end

  assign BUS_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence lock_write_s(logic key);
    BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_LOCK && lock_key == key
      && BUS_REQ.wdata[15:0] == 16'h0001;
  endsequence

  sequence lock_three_s;
    // At most one other bus cycle may sit between each pair of the three key writes
    lock_write_s(1'b1) ##[1:2] lock_write_s(1'b0) ##[1:2] lock_write_s(1'b1);
  endsequence

  lock_sequence_a: assert property (!lock_on_q ##0 lock_three_s |=> lock_on_q && lock_q[0])
    else $error("Lock sequence did not engage lock");

  lock_hold_a: assert property (lock_q[0] && BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_MODE
    |=> mode_q[1:0] == $past(mode_q[1:0]))
    else $error("Locked pin mode changed");

  pend_set_a: assert property ((|hit_vec) |=> (pend_q & $past(hit_vec)) == $past(hit_vec))
    else $error("Detected edge not recorded as pending");

  clear_one_a: assert property (BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_PCLR
    |=> (pend_q & $past(BUS_REQ.wdata[28:0]) & ~$past(hit_vec)) == 29'h0000_0000)
    else $error("Pending bit not cleared by a one");

  clear_zero_a: assert property (BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_PCLR
    |=> ($past(pend_q) & ~$past(BUS_REQ.wdata[28:0]) & ~pend_q) == 29'h0000_0000)
    else $error("Pending bit lost on a zero write");

  irq_hold_a: assert property ((|(pend_q & ien_q)) && !(BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_PCLR)
    && !(BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_IEN) |=> IRQ)
    else $error("Interrupt dropped before clear");

  event_mask_a: assert property (1'b1 |=> EVENT_OUT == ($past(hit_vec) & $past(een_q)))
    else $error("Event output ignores mask");

  odata_pin_a: assert property (BUS_REQ.wr && BUS_REQ.addr == gpe_pkg::ADDR_ODATA
    && mode_q[1:0] == gpe_pkg::MODE_OUTPUT && !otype_q[0] ##1 mode_q[1:0] == gpe_pkg::MODE_OUTPUT
    |=> PIN_OUT[0] == $past(BUS_REQ.wdata[0], 2))
    else $error("Output write not on pin two cycles later");
endmodule
`default_nettype wire

// ===== gpe_pin_model.sv
// Pin-side partner: pad level resolution and short internal event pulses
`timescale 1ns/100ps
`default_nettype none
module gpe_pin_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] pull_up,
  input  wire logic [15:0] pull_dn,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  input  wire logic        fire,
  output logic [15:0]      pin_in,
  output logic [12:0]      int_evt
);
  // Floating pads read inverted, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (pull_up[i]) pin_in[i] = 1'b1;
      else if (pull_dn[i]) pin_in[i] = 1'b0;
      else pin_in[i] = ~pin_out[i];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pulse far shorter than a clock period
  initial begin
    int_evt = 13'h0000;
    forever begin
      @(posedge fire);
      int_evt[0] = 1'b1;
      #3;
      int_evt[0] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== gpe_port_top_tb.sv
// Self-checking bench for the GPIO port with edge event lines
`timescale 1ns/100ps
`default_nettype none
module gpe_port_top_tb;
  logic                     clk, rst_n, irq, wake, fire, hit;
  gpe_pkg::gpe_bus_req_type bus;
  logic [31:0]              rdata, speed;
  logic [15:0]              pin_in, pin_out, oe_n, pu, pd, ext_en, ext_val, af_in;
  logic [15:0][7:0]         af_out;
  logic [12:0]              int_evt;
  logic [28:0]              ev_out;
  int                       err_total, n_checks;

  gpe_port_top DUT (.CLK(clk), .RESET_N(rst_n), .BUS_REQ(bus), .BUS_RDATA(rdata),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_PULL_UP(pu),
    .PIN_PULL_DOWN(pd), .PIN_SPEED(speed), .AF_OUT(af_out), .AF_IN(af_in),
    .OTHER_PINS_IN(68'h0), .INT_EVENT_IN(int_evt), .IRQ(irq), .EVENT_OUT(ev_out),
    .WAKE_OUT(wake));
  gpe_pin_model pads (.pin_out(pin_out), .pin_oe_n(oe_n), .pull_up(pu), .pull_dn(pd),
    .ext_en(ext_en), .ext_val(ext_val), .fire(fire), .pin_in(pin_in), .int_evt(int_evt));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    bus = '0;
    fire = 1'b0;
    hit = 1'b0;
    ext_en = 16'hFFF0;
    ext_val = 16'hA5A0;
    af_out = '0;
    af_out[3] = 8'h20;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(gpe_pkg::ADDR_MODE, 32'h0, "mode reset");
    rd(8'h30, 32'h0, "unmapped read");
    wr(gpe_pkg::ADDR_MODE, 32'h0000_0001);
    wr(gpe_pkg::ADDR_ODATA, 32'h0000_0001);
    wr(gpe_pkg::ADDR_SPEED, 32'h0000_00E4);
    wr(gpe_pkg::ADDR_PULL, 32'h0000_0020);
    rd(gpe_pkg::ADDR_SPEED, 32'h0000_00E4, "speed");
    chk("pin speed", 32'h0000_00E4, speed);
    chk("pull up", 32'h0, 32'(pu));
    chk("drive pin0", 32'h1, {30'h0, oe_n[0], pin_out[0]});
    chk("pull pin2", 32'h1, 32'(pd[2]));
    wr(gpe_pkg::ADDR_LOCK, 32'h0001_0001);
    wr(gpe_pkg::ADDR_LOCK, 32'h0000_0001);
    wr(gpe_pkg::ADDR_LOCK, 32'h0001_0001);
    rd(gpe_pkg::ADDR_LOCK, 32'h0001_0001, "lock state");
    wr(gpe_pkg::ADDR_AF_LO, 32'h0000_5000);
    wr(gpe_pkg::ADDR_MODE, 32'h0000_0084);
    rd(gpe_pkg::ADDR_MODE, 32'h0000_0085, "locked mode");
    chk("alt pin3", 32'h1, {30'h0, oe_n[3], pin_out[3]});
    rd(gpe_pkg::ADDR_IDATA, 32'h0000_A5A9, "input data");
    chk("alt input", 32'h0000_A5A9, 32'(af_in));
    wr(gpe_pkg::ADDR_RISE, 32'h0001_0004);
    wr(gpe_pkg::ADDR_IEN, 32'h0000_0004);
    wr(gpe_pkg::ADDR_EEN, 32'h0000_0004);
    rd(gpe_pkg::ADDR_PEND, 32'h0, "idle pending");
    ext_en[2] <= 1'b1;
    ext_val[2] <= 1'b1;
    @(negedge clk);
    chk("wake early", 32'h1, 32'(wake));
    for (int i = 0; i < 10 && irq !== 1'b1; i++) @(negedge clk);
    if (irq !== 1'b1) begin
      err_total++;
      finish_test();
    end
    chk("event pin2", 32'h1, 32'(ev_out[2]));
    rd(gpe_pkg::ADDR_PEND, 32'h0000_0004, "pending");
    wr(gpe_pkg::ADDR_PCLR, 32'h0);
    rd(gpe_pkg::ADDR_PEND, 32'h0000_0004, "zero clear");
    chk("irq held", 32'h1, 32'(irq));
    wr(gpe_pkg::ADDR_PCLR, 32'h0000_0004);
    @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    ext_val[2] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(gpe_pkg::ADDR_PEND, 32'h0, "fall ignored");
    fire <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (ev_out[16] !== 1'b0 || irq !== 1'b0) hit = 1'b1;
    end
    rd(gpe_pkg::ADDR_PEND, 32'h0001_0000, "short pulse");
    chk("masked line", 32'h0, 32'(hit));
    finish_test();
  end
endmodule
`default_nettype wire
